// *** uart_tx_pkg.sv ***
// Constants, field layouts and carrier types for the UART transmit and
// line format block. Assumes one 100 MHz clock and a synchronous host port.
// Operation
// [RULE1] Buffer written characters, shift them out serially
// [RULE2] Disabled FIFO holds one byte; overflow discarded
// [RULE3] FIFO control is write-only; reads return zero
// [RULE4] Bits 7:6 pick receive threshold 8/16/56/60
// [RULE5] Bits 5:4 pick transmit free-space threshold 8/16/32/56
// [RULE6] Transmit threshold writable only with enhanced enable
// [RULE7] Bit 3 selects DMA signalling mode
// [RULE8] Bit 2 flushes transmit FIFO, self-clears
// [RULE9] Bit 1 flushes receive FIFO, self-clears
// [RULE10] Bit 0 enables both FIFOs, default off
// [RULE11] Line format bit 7 is divisor latch enable
// [RULE12] Divisor bytes only with latch bit; normal otherwise
// [RULE13] Break bit forces serial output low
// [RULE14] Bit 3 enables parity append and check
// [RULE15] Bit 4 chooses even, else odd parity
// [RULE16] Bit 5 forces parity to inverse of bit 4
// [RULE17] Bit 2 selects one or 1.5/2 stop bits
// [RULE18] Bits 1:0 set character length 5 to 8
// [RULE19] Triggers compare free or stored count to threshold
`default_nettype none
package uart_tx_pkg;
    localparam logic [2:0] ADDR_TX_HOLD   = 3'h0;
    localparam logic [2:0] ADDR_DIV_LOW   = 3'h0;
    localparam logic [2:0] ADDR_DIV_HIGH  = 3'h1;
    localparam logic [2:0] ADDR_FIFO_CTRL = 3'h2;
    localparam logic [2:0] ADDR_ENH_FEAT  = 3'h2;
    localparam logic [2:0] ADDR_LINE_FMT  = 3'h3;
    localparam logic [2:0] ADDR_TX_STATUS = 3'h5;
    localparam logic [7:0] ENH_ACCESS_KEY = 8'hBF;

    localparam int FC_RX_TRIG_LSB = 6;
    localparam int FC_TX_TRIG_LSB = 4;
    localparam int FC_DMA_MODE    = 3;
    localparam int FC_TX_RESET    = 2;
    localparam int FC_RX_RESET    = 1;
    localparam int FC_ENABLE      = 0;
    localparam int LF_DIV_LATCH   = 7;
    localparam int LF_BREAK       = 6;
    localparam int LF_FORCE_PAR   = 5;
    localparam int LF_EVEN_PAR    = 4;
    localparam int LF_PAR_EN      = 3;
    localparam int LF_STOP_LEN    = 2;
    localparam int LF_WLEN_LSB    = 0;
    localparam int EF_ENH_EN      = 4;
    localparam int ST_TX_EMPTY    = 6;
    localparam int ST_HOLD_EMPTY  = 5;

    localparam logic [7:0]  LINE_FMT_RESET  = 8'h00;
    localparam logic [7:0]  ENH_FEAT_RESET  = 8'h00;
    localparam logic [1:0]  TRIG_SEL_RESET  = 2'h0;
    localparam logic [15:0] DIVISOR_RESET   = 16'h0001;

    localparam int         FIFO_AW       = 6;
    localparam logic [6:0] FIFO_DEPTH    = 7'h40;
    // Sixteen baud ticks per bit; stop lengths are last tick indices
    localparam logic [4:0] BIT_LAST      = 5'h0F;
    localparam logic [4:0] STOP_ONE_LAST = 5'h0F;
    localparam logic [4:0] STOP_MID_LAST = 5'h17;
    localparam logic [4:0] STOP_TWO_LAST = 5'h1F;

    typedef struct packed {
        logic [2:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_type;

    function automatic logic [6:0] rx_threshold(input logic [1:0] sel);
        unique case (sel)
            2'h0: rx_threshold = 7'h08;
            2'h1: rx_threshold = 7'h10;
            2'h2: rx_threshold = 7'h38;
            2'h3: rx_threshold = 7'h3C;
        endcase
    endfunction : rx_threshold

    function automatic logic [6:0] tx_threshold(input logic [1:0] sel);
        unique case (sel)
            2'h0: tx_threshold = 7'h08;
            2'h1: tx_threshold = 7'h10;
            2'h2: tx_threshold = 7'h20;
            2'h3: tx_threshold = 7'h38;
        endcase
    endfunction : tx_threshold

    function automatic logic [7:0] word_mask(input logic [1:0] sel);
        unique case (sel)
            2'h0: word_mask = 8'h1F;
            2'h1: word_mask = 8'h3F;
            2'h2: word_mask = 8'h7F;
            2'h3: word_mask = 8'hFF;
        endcase
    endfunction : word_mask

    function automatic logic [2:0] word_last(input logic [1:0] sel);
        word_last = 3'h4 + {1'b0, sel};
    endfunction : word_last
endpackage : uart_tx_pkg
`default_nettype wire

// *** tx_hold_fifo.sv ***
// Transmit holding FIFO, 64 bytes deep, one byte deep while disabled.
// Push and pop come from logic on the same clock.
`default_nettype none
module tx_hold_fifo (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Control
    input  wire logic       fifo_en,
    input  wire logic       flush,
    // Fill side
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    // Drain side
    input  wire logic       pop,
    output logic      [7:0] pop_data,
    // Status
    output logic      [6:0] count,
    output logic            full,
    output logic            empty
);
    typedef struct packed {
        logic [63:0][7:0]             mem;
        logic [uart_tx_pkg::FIFO_AW-1:0] wr_ptr;
        logic [uart_tx_pkg::FIFO_AW-1:0] rd_ptr;
        logic [6:0]                   count;
    } fifo_state_type;

    fifo_state_type s;
    fifo_state_type n;
    logic           do_push;
    logic           do_pop;

    assign full     = fifo_en ? (s.count == uart_tx_pkg::FIFO_DEPTH)
                              : (s.count != 7'h00); // RULE2
    assign empty    = s.count == 7'h00;
    assign count    = s.count;
    assign pop_data = s.mem[s.rd_ptr];

    always_comb begin
        n       = s;
        do_push = push && !full; // RULE2
        do_pop  = pop && !empty;
        if (flush) begin
            n.wr_ptr = '0; // RULE8
            n.rd_ptr = '0;
            n.count  = 7'h00;
        end else begin
            if (do_push) begin
                n.mem[s.wr_ptr] = push_data; // RULE1
                n.wr_ptr        = s.wr_ptr + 6'h01;
            end
            if (do_pop)
                n.rd_ptr = s.rd_ptr + 6'h01;
            n.count = s.count + {6'h00, do_push} - {6'h00, do_pop};
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            s <= '0;
        else
            s <= n;
    end
endmodule : tx_hold_fifo
`default_nettype wire

// *** baud_tick_gen.sv ***
// Sixteen-times baud tick from the programmed divisor.
// A divisor of zero behaves as one, so the tick never stops.
`default_nettype none
module baud_tick_gen (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Divisor and tick
    input  wire logic [15:0] divisor,
    output logic             tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } baud_state_type;

    baud_state_type s;
    baud_state_type n;

    assign tick = s.tick;

    always_comb begin
        n      = s;
        n.tick = ({1'b0, s.cnt} + 17'h00001) >= {1'b0, divisor};
        n.cnt  = n.tick ? 16'h0000 : s.cnt + 16'h0001;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            s <= '0;
        else
            s <= n;
    end
endmodule : baud_tick_gen
`default_nettype wire

// *** uart_tx_line_format.sv ***
// UART transmit path with FIFO control and line format registers.
// Host strobes are one-cycle pulses on mclk; receiver logic sits outside
// and takes its format, flush and trigger from the ports below, and drives its level into rx_level.
`default_nettype none
module uart_tx_line_format (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    // Host register port
    input  wire uart_tx_pkg::reg_req_type reg_req,
    output logic                    [7:0] reg_rdata,
    // Serial line
    output logic                          tx,
    // Receive FIFO companion
    input  wire logic               [6:0] rx_level,
    output logic                          rx_flush,
    output logic                          rx_trigger,
    // Mode and trigger outputs
    output logic                    [7:0] line_format,
    output logic                          fifo_enable,
    output logic                          dma_mode,
    output logic                          tx_trigger
);
    typedef enum logic [4:0] {
        TX_IDLE   = 5'b00001,
        TX_START  = 5'b00010,
        TX_DATA   = 5'b00100,
        TX_PARITY = 5'b01000,
        TX_STOP   = 5'b10000
    } tx_state_type;

    typedef struct packed {
        logic [7:0]   line_fmt;
        logic [7:0]   enh_feat;
        logic [15:0]  divisor;
        logic         fifo_en;
        logic [1:0]   rx_trig_sel;
        logic [1:0]   tx_trig_sel;
        logic         dma_mode;
        logic         tx_flush;
        logic         rx_flush;
        logic         rx_trig;
        logic         tx_trig;
        logic [7:0]   rdata;
        tx_state_type tx_state;
        logic [7:0]   shift;
        logic [2:0]   bit_idx;
        logic [4:0]   tick_cnt;
        logic         parity_bit;
        logic         tx_line;
        logic         tx_out;
    } core_state_type;

    localparam core_state_type CORE_RESET = '{
        line_fmt:    uart_tx_pkg::LINE_FMT_RESET,
        enh_feat:    uart_tx_pkg::ENH_FEAT_RESET,
        divisor:     uart_tx_pkg::DIVISOR_RESET,
        fifo_en:     1'b0,
        rx_trig_sel: uart_tx_pkg::TRIG_SEL_RESET,
        tx_trig_sel: uart_tx_pkg::TRIG_SEL_RESET,
        dma_mode:    1'b0,
        tx_flush:    1'b0,
        rx_flush:    1'b0,
        rx_trig:     1'b0,
        tx_trig:     1'b0,
        rdata:       8'h00,
        tx_state:    TX_IDLE,
        shift:       8'h00,
        bit_idx:     3'h0,
        tick_cnt:    5'h00,
        parity_bit:  1'b0,
        tx_line:     1'b1,
        tx_out:      1'b1
    };

    core_state_type s;
    core_state_type n;
    logic           push;
    logic           pop;
    logic [7:0]     fifo_data;
    logic [6:0]     fifo_count;
    logic           fifo_full;
    logic           fifo_empty;
    logic           tick;
    logic           dlab;
    logic           enh_sel;
    logic [7:0]     masked;
    logic [4:0]     stop_last;
    logic [6:0]     free_slots;

    tx_hold_fifo u_fifo (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .fifo_en   (s.fifo_en),
        .flush     (s.tx_flush),
        .push      (push),
        .push_data (reg_req.wdata),
        .pop       (pop),
        .pop_data  (fifo_data),
        .count     (fifo_count),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );

    baud_tick_gen u_baud (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .divisor (s.divisor),
        .tick    (tick)
    );

    assign reg_rdata   = s.rdata;
    assign tx          = s.tx_out;
    assign rx_flush    = s.rx_flush;
    assign rx_trigger  = s.rx_trig;
    assign tx_trigger  = s.tx_trig;
    assign line_format = s.line_fmt;
    assign fifo_enable = s.fifo_en;
    assign dma_mode    = s.dma_mode;

    always_comb begin
        n          = s;
        push       = 1'b0;
        pop        = 1'b0;
        n.tx_flush = 1'b0; // RULE8
        n.rx_flush = 1'b0; // RULE9
        dlab       = s.line_fmt[uart_tx_pkg::LF_DIV_LATCH]; // RULE11
        enh_sel    = s.line_fmt == uart_tx_pkg::ENH_ACCESS_KEY;
        masked     = fifo_data
                   & uart_tx_pkg::word_mask(s.line_fmt[1:0]); // RULE18
        free_slots = uart_tx_pkg::FIFO_DEPTH - fifo_count;
        // Half a stop bit extra only makes sense for 5-bit characters
        if (!s.line_fmt[uart_tx_pkg::LF_STOP_LEN])
            stop_last = uart_tx_pkg::STOP_ONE_LAST; // RULE17
        else if (s.line_fmt[1:0] == 2'h0)
            stop_last = uart_tx_pkg::STOP_MID_LAST; // RULE17
        else
            stop_last = uart_tx_pkg::STOP_TWO_LAST; // RULE17

        // Host writes
        if (reg_req.wr) begin
            if (reg_req.addr == uart_tx_pkg::ADDR_LINE_FMT) begin
                n.line_fmt = reg_req.wdata;
            end else if (dlab && reg_req.addr == uart_tx_pkg::ADDR_DIV_LOW)
            begin
                n.divisor[7:0] = reg_req.wdata; // RULE12
            end else if (dlab && reg_req.addr == uart_tx_pkg::ADDR_DIV_HIGH)
            begin
                n.divisor[15:8] = reg_req.wdata; // RULE12
            end else if (enh_sel
                         && reg_req.addr == uart_tx_pkg::ADDR_ENH_FEAT) begin
                n.enh_feat = reg_req.wdata;
            end else if (!dlab && reg_req.addr == uart_tx_pkg::ADDR_TX_HOLD)
            begin
                push = 1'b1; // RULE1
            end else if (!dlab
                         && reg_req.addr == uart_tx_pkg::ADDR_FIFO_CTRL) begin
                n.rx_trig_sel = reg_req.wdata[7:6]; // RULE4
                if (s.enh_feat[uart_tx_pkg::EF_ENH_EN])
                    n.tx_trig_sel = reg_req.wdata[5:4]; // RULE6
                n.dma_mode = reg_req.wdata[uart_tx_pkg::FC_DMA_MODE]; // RULE7
                n.tx_flush = reg_req.wdata[uart_tx_pkg::FC_TX_RESET]; // RULE8
                n.rx_flush = reg_req.wdata[uart_tx_pkg::FC_RX_RESET]; // RULE9
                n.fifo_en  = reg_req.wdata[uart_tx_pkg::FC_ENABLE]; // RULE10
            end
        end

        // Host reads, answered one cycle later
        if (reg_req.rd) begin
            n.rdata = 8'h00; // RULE3
            if (reg_req.addr == uart_tx_pkg::ADDR_LINE_FMT)
                n.rdata = s.line_fmt;
            else if (dlab && reg_req.addr == uart_tx_pkg::ADDR_DIV_LOW)
                n.rdata = s.divisor[7:0];
            else if (dlab && reg_req.addr == uart_tx_pkg::ADDR_DIV_HIGH)
                n.rdata = s.divisor[15:8];
            else if (enh_sel && reg_req.addr == uart_tx_pkg::ADDR_ENH_FEAT)
                n.rdata = s.enh_feat;
            else if (!dlab && reg_req.addr == uart_tx_pkg::ADDR_TX_STATUS)
            begin
                n.rdata[uart_tx_pkg::ST_HOLD_EMPTY] = fifo_empty;
                n.rdata[uart_tx_pkg::ST_TX_EMPTY] = fifo_empty
                    && (s.tx_state == TX_IDLE);
            end
        end

        // Triggers
        n.tx_trig = free_slots
                  >= uart_tx_pkg::tx_threshold(s.tx_trig_sel); // RULE5 RULE19
        n.rx_trig = rx_level
                  >= uart_tx_pkg::rx_threshold(s.rx_trig_sel); // RULE4 RULE19

        // Serialiser
        unique case (s.tx_state)
            TX_IDLE: begin
                if (!fifo_empty && !s.tx_flush) begin
                    pop        = 1'b1; // RULE1
                    n.shift    = fifo_data;
                    n.bit_idx  = 3'h0;
                    n.tick_cnt = 5'h00;
                    n.tx_line  = 1'b0;
                    n.tx_state = TX_START;
                    if (s.line_fmt[uart_tx_pkg::LF_FORCE_PAR])
                        n.parity_bit =
                            !s.line_fmt[uart_tx_pkg::LF_EVEN_PAR]; // RULE16
                    else if (s.line_fmt[uart_tx_pkg::LF_EVEN_PAR])
                        n.parity_bit = ^masked; // RULE15
                    else
                        n.parity_bit = ~^masked; // RULE15
                end
            end
            TX_START: begin
                if (tick) begin
                    n.tick_cnt = s.tick_cnt + 5'h01;
                    if (s.tick_cnt == uart_tx_pkg::BIT_LAST) begin
                        n.tick_cnt = 5'h00;
                        n.tx_line  = s.shift[0];
                        n.tx_state = TX_DATA;
                    end
                end
            end
            TX_DATA: begin
                if (tick) begin
                    n.tick_cnt = s.tick_cnt + 5'h01;
                    if (s.tick_cnt == uart_tx_pkg::BIT_LAST) begin
                        n.tick_cnt = 5'h00;
                        if (s.bit_idx
                            == uart_tx_pkg::word_last(s.line_fmt[1:0])) begin
                            if (s.line_fmt[uart_tx_pkg::LF_PAR_EN]) begin
                                n.tx_line  = s.parity_bit; // RULE14
                                n.tx_state = TX_PARITY;
                            end else begin
                                n.tx_line  = 1'b1;
                                n.tx_state = TX_STOP;
                            end
                        end else begin
                            n.bit_idx = s.bit_idx + 3'h1; // RULE18
                            n.shift   = {1'b0, s.shift[7:1]};
                            n.tx_line = s.shift[1];
                        end
                    end
                end
            end
            TX_PARITY: begin
                if (tick) begin
                    n.tick_cnt = s.tick_cnt + 5'h01;
                    if (s.tick_cnt == uart_tx_pkg::BIT_LAST) begin
                        n.tick_cnt = 5'h00;
                        n.tx_line  = 1'b1;
                        n.tx_state = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                if (tick) begin
                    n.tick_cnt = s.tick_cnt + 5'h01;
                    if (s.tick_cnt >= stop_last) begin
                        n.tick_cnt = 5'h00;
                        n.tx_state = TX_IDLE;
                    end
                end
            end
            default: begin
                n.tx_state = TX_IDLE;
                n.tx_line  = 1'b1;
            end
        endcase
        // Break overrides the frame but lets the serialiser run on
        n.tx_out = n.tx_line && !s.line_fmt[uart_tx_pkg::LF_BREAK]; // RULE13
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            s <= CORE_RESET;
        else
            s <= n;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic fc_wr;
    assign fc_wr = reg_req.wr && !dlab
                && reg_req.addr == uart_tx_pkg::ADDR_FIFO_CTRL;

    sequence s_flush_pulse;
        s.tx_flush ##1 (!s.tx_flush && fifo_count == 7'h00);
    endsequence

    sequence s_frame_start;
        (s.tx_state == TX_START && !s.tx_out) [*2];
    endsequence

    property p_overflow_dropped;
        (fifo_full && push && !pop && !s.tx_flush)
            |=> fifo_count == $past(fifo_count);
    endproperty
    a_overflow_dropped: assert property (p_overflow_dropped) // RULE2
        else $error("write into full holding fifo was stored");

    property p_fc_read_zero;
        (reg_req.rd && !dlab && !enh_sel
            && reg_req.addr == uart_tx_pkg::ADDR_FIFO_CTRL)
            |=> reg_rdata == 8'h00;
    endproperty
    a_fc_read_zero: assert property (p_fc_read_zero) // RULE3
        else $error("fifo control read returned data");

    property p_tx_trig_locked;
        (fc_wr && !s.enh_feat[uart_tx_pkg::EF_ENH_EN])
            |=> $stable(s.tx_trig_sel);
    endproperty
    a_tx_trig_locked: assert property (p_tx_trig_locked) // RULE6
        else $error("tx threshold changed without enhanced enable");

    property p_tx_flush;
        (fc_wr && reg_req.wdata[uart_tx_pkg::FC_TX_RESET]) |=> s_flush_pulse;
    endproperty
    a_tx_flush: assert property (p_tx_flush) // RULE8
        else $error("tx flush did not empty fifo and self-clear");

    property p_rx_flush;
        (fc_wr && reg_req.wdata[uart_tx_pkg::FC_RX_RESET])
            |=> rx_flush ##1 !rx_flush;
    endproperty
    a_rx_flush: assert property (p_rx_flush) // RULE9
        else $error("rx flush pulse wrong");

    property p_break_low;
        s.line_fmt[uart_tx_pkg::LF_BREAK] |=> !tx;
    endproperty
    a_break_low: assert property (p_break_low) // RULE13
        else $error("tx not low during break");

    property p_divisor_guard;
        (reg_req.wr && !dlab && reg_req.addr != uart_tx_pkg::ADDR_LINE_FMT)
            |=> $stable(s.divisor);
    endproperty
    a_divisor_guard: assert property (p_divisor_guard) // RULE12
        else $error("divisor written with latch bit clear");

    property p_start_bit;
        (s.tx_state == TX_IDLE && !fifo_empty && !s.tx_flush
            && !s.line_fmt[uart_tx_pkg::LF_BREAK])
            |=> s_frame_start;
    endproperty
    a_start_bit: assert property (p_start_bit) // RULE1
        else $error("start bit not driven after fifo had data");

    property p_rx_trigger;
        1'b1 |=> rx_trigger == ($past(rx_level)
            >= uart_tx_pkg::rx_threshold($past(s.rx_trig_sel)));
    endproperty
    a_rx_trigger: assert property (p_rx_trigger) // RULE19
        else $error("rx trigger disagrees with level");
endmodule : uart_tx_line_format
`default_nettype wire

// *** serial_rx_model.sv ***
// Far-end serial receiver that decodes frames seen on the transmit line.
// Assumes a divisor of one, so each bit lasts 16 mclk cycles.
`default_nettype none
module serial_rx_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Line and format
    input  wire logic       tx,
    input  wire logic [7:0] line_format,
    // Decoded frame
    output var logic  [7:0] rx_data,
    output var logic        rx_par,
    output var int          frames,
    output var time         start_t
);
    timeunit 1ns;
    timeprecision 1ps;
    // Samples mid-bit, so edges launched at posedge never race the sample
    initial begin
        frames = 0;
        start_t = 0;
        wait (rst_b === 1'b1);
        forever begin
            @(negedge tx);
            start_t = $time;
            repeat (8) @(posedge mclk);
            rx_data = 8'h00;
            rx_par = 1'b0;
            for (int i = 0; i < 5 + line_format[1:0]; i++) begin
                repeat (16) @(posedge mclk);
                rx_data[i] = tx;
            end
            if (line_format[3] === 1'b1) begin
                repeat (16) @(posedge mclk);
                rx_par = tx;
            end
            repeat (16) @(posedge mclk);
            frames++;
        end
    end
endmodule : serial_rx_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the UART transmit and line format block.
// Assumes serial_rx_model on the line and the reset divisor of one.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     mclk;
    logic                     rst_b;
    uart_tx_pkg::reg_req_type reg_req;
    logic               [7:0] rdata;
    logic                     tx;
    logic               [6:0] rx_level;
    logic                     rx_flush;
    logic                     rx_trig;
    logic               [7:0] lf;
    logic                     fen;
    logic                     dma;
    logic                     tx_trig;
    logic               [7:0] rx_data;
    logic                     rx_par;
    int                       frames;
    time                      start_t;
    time                      t0;
    int                       num_errors;
    int                       cmp_count;
    logic               [7:0] fmts [6] = '{8'h1B, 8'h0A, 8'h2A, 8'h3A,
                                           8'h00, 8'h05};
    logic               [6:0] tx_holding_fifo [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};

    uart_tx_line_format dut (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(rdata), .tx(tx), .rx_level(rx_level),
        .rx_flush(rx_flush), .rx_trigger(rx_trig), .line_format(lf),
        .fifo_enable(fen), .dma_mode(dma), .tx_trigger(tx_trig));
    serial_rx_model far_end (.mclk(mclk), .rst_b(rst_b), .tx(tx),
        .line_format(lf), .rx_data(rx_data), .rx_par(rx_par),
        .frames(frames), .start_t(start_t));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic close_out;
        $display("Compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge mclk);
        reg_req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
        @(negedge mclk);
        reg_req.addr = a;
        reg_req.rd = 1'b1;
        @(negedge mclk);
        reg_req.rd = 1'b0;
        @(negedge mclk);
        check(rdata & m, exp);
    endtask : rd

    // Waits for the next decoded frame; a missing frame ends the run
    task automatic frame(input logic [7:0] d, input logic p);
        int n;
        n = frames;
        for (int i = 0; i < 400 && frames == n; i++) @(negedge mclk);
        if (frames == n) begin
            num_errors++;
            close_out();
        end
        check(rx_data, d);
        check({7'h0, rx_par}, {7'h0, p});
    endtask : frame

    function automatic logic par_of(input logic [7:0] f, input logic [7:0] d);
        if (f[3] !== 1'b1) return 1'b0;
        if (f[5] === 1'b1) return ~f[4];
        return f[4] ? ^d : ~^d;
    endfunction : par_of

    initial begin
        logic [7:0] d;
        rst_b = 1'b0;
        reg_req = '0;
        rx_level = 7'h00;
        num_errors = 0;
        cmp_count = 0;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        rd(3'h3, 8'hFF, 8'h00);
        check({7'h0, fen}, 8'h00);
        rd(3'h7, 8'hFF, 8'h00);
        foreach (fmts[i]) begin
            d = 8'hA7 & (8'hFF >> (2'h3 - fmts[i][1:0]));
            wr(3'h3, fmts[i]);
            rd(3'h3, 8'hFF, fmts[i]);
            wr(3'h0, 8'hA7);
            frame(d, par_of(fmts[i], d));
        end
        // Let the last frame finish so the one-byte store starts empty
        repeat (40) @(negedge mclk);
        // Frame spacing gives stop length; third byte overflows one slot
        for (int k = 0; k < 2; k++) begin
            wr(3'h3, k ? 8'h07 : 8'h04);
            wr(3'h0, 8'h11);
            wr(3'h0, 8'h12);
            wr(3'h0, 8'h13);
            frame(8'h11, 1'b0);
            t0 = start_t;
            frame(8'h12, 1'b0);
            d = 8'((start_t - t0) / 10 - (k ? 176 : 120));
            check({7'h0, d inside {8'h01, 8'h02}}, 8'h01);
            repeat (250) @(negedge mclk);
            check(8'(frames), 8'(6 + 2 * k + 2));
        end
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        rd(3'h0, 8'hFF, 8'h01);
        wr(3'h3, 8'h03);
        rd(3'h5, 8'h60, 8'h60);
        wr(3'h2, 8'h0B);
        check({5'h0, rx_flush, dma, fen}, 8'h07);
        @(negedge mclk);
        check({7'h0, rx_flush}, 8'h00);
        rd(3'h2, 8'hFF, 8'h00);
        foreach (tx_holding_fifo[s]) begin
            wr(3'h2, {2'(s), 6'h01});
            rx_level = tx_holding_fifo[s] - 7'h01;
            repeat (3) @(negedge mclk);
            check({7'h0, rx_trig}, 8'h00);
            rx_level = tx_holding_fifo[s];
            repeat (3) @(negedge mclk);
            check({7'h0, rx_trig}, 8'h01);
        end
        wr(3'h2, 8'h11);
        repeat (52) wr(3'h0, 8'h5A);
        repeat (2) @(negedge mclk);
        check({7'h0, tx_trig}, 8'h01);
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h10);
        wr(3'h3, 8'h03);
        wr(3'h2, 8'h11);
        repeat (2) @(negedge mclk);
        check({7'h0, tx_trig}, 8'h00);
        wr(3'h2, 8'h15);
        repeat (2) @(negedge mclk);
        check({7'h0, tx_trig}, 8'h01);
        rd(3'h5, 8'h60, 8'h20);
        wr(3'h3, 8'h43);
        repeat (50) @(negedge mclk);
        check({7'h0, tx}, 8'h00);
        close_out();
    end
endmodule : testbench
`default_nettype wire
